// ---- src/pic_irq_ctrl.v ----
// primary interrupt controller: edge select, global enable, request
// flags and enables of the primary sources, axi4-lite register slave.
// assumes event inputs are one-cycle pulses (or levels sampled each
// cycle), pins and groups synchronous to aclk.
//
// Contract
// - pin b detection is chosen by bits 3:2: off, rising, falling, both.
// - pin a detection is chosen by bits 1:0 with the same encoding.
// - upper four bits of the edge select register read as zero.
// - top bit of the first control register reads as zero.
// - bit 0 of the first control register is the global enable.
// - bit 6 of the first control register is the group 0 request flag.
// - bit 3 of the first control register enables group 0.
// - bit 5 of the first control register is set by a comparator event.
// - bit 2 of the first control register enables the comparator.
// - bit 4 flags the selected pin a edge, bit 1 enables it.
// - second register holds group 1 flag at bit 4, enable at bit 0.
// - second register holds time base 0 enable at 3, flag at 7.
// - each multi-function group merges several sub-sources.
//
// ----------------------------------------------------------------
// register layout
// ----------------------------------------------------------------
// ext_edge_select, byte address 0x0
//   bits 7:4  no function, read as zero
//   bits 3:2  pin b edge choice
//   bits 1:0  pin a edge choice
//   encoding  00 off, 01 rising, 10 falling, 11 both
// irq_ctrl_first, byte address 0x4
//   bit 7     no function, read as zero
//   bit 6     group 0 request flag
//   bit 5     comparator request flag
//   bit 4     pin a request flag
//   bit 3     group 0 enable
//   bit 2     comparator enable
//   bit 1     pin a enable
//   bit 0     global enable
// irq_ctrl_second, byte address 0x8
//   bits 7:4  flags: time base 0, converter, group 2, group 1
//   bits 3:0  enables in the same order
// irq_ctrl_third, byte address 0xc
//   bits 7:4  flags: uart, serial module, pin b, time base 1
//   bits 3:0  enables in the same order
//
// ----------------------------------------------------------------
// timing and limits
// ----------------------------------------------------------------
// an event sampled at one edge shows in its flag after that edge,
// and the matching request line follows combinationally.
// flags are plain read/write: software clears a flag by writing a
// zero, so a read-modify-write that races an event can lose it: only
// a set in the same cycle as the write always wins.
// only byte lane 0 carries register data; a write with lane 0
// strobe low is answered okay and changes nothing.
// an address outside the four registers answers with slave error
// and leaves every register untouched.
// pins are taken as synchronous; a pin held high across reset
// release shows one rising edge, since the prior level resets low.
// the bus answers one cycle after it has taken both address and
// data (write) or the address (read), and holds the answer until
// the master accepts it.
// no vector or priority logic sits here: each source has its own
// request line and the core arbitrates between them.
`timescale 1ns/1ns
`include "pic_map.vh"

module pic_irq_ctrl (
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // external pins
  input wire ext_irq_pin_a,
  input wire ext_irq_pin_b,
  // event sources
  input wire comparator_evt,
  input wire [7:0] multi_group0_src,
  input wire [7:0] multi_group1_src,
  input wire [7:0] multi_group2_src,
  input wire converter_evt,
  input wire timebase_zero_evt,
  input wire timebase_one_evt,
  input wire serial_module_evt,
  input wire async_serial_evt,
  // to the core, one line per vector
  output wire irq_pin_a,
  output wire irq_comparator,
  output wire irq_group0,
  output wire irq_group1,
  output wire irq_group2,
  output wire irq_converter,
  output wire irq_timebase0,
  output wire irq_timebase1,
  output wire irq_serial_module,
  output wire irq_async_serial,
  output wire irq_pin_b,
  output wire irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [3:0] edge_sel_q;
  reg [6:0] ctl0_q;
  reg [7:0] ctl1_q;
  reg [7:0] ctl2_q;
  reg pin_a_q;
  reg pin_b_q;
  reg [3:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  wire [1:0] pin_a_edge_sel = edge_sel_q[`PIC_PIN_A_SEL];
  wire [1:0] pin_b_edge_sel = edge_sel_q[`PIC_PIN_B_SEL];
  wire a_rise = ext_irq_pin_a & ~pin_a_q;
  wire a_fall = ~ext_irq_pin_a & pin_a_q;
  wire b_rise = ext_irq_pin_b & ~pin_b_q;
  wire b_fall = ~ext_irq_pin_b & pin_b_q;
  reg pin_a_hit;
  reg pin_b_hit;

  // per-pin edge choice from its two-bit field
  always @* begin
    case (pin_a_edge_sel)
      `PIC_EDGE_OFF: pin_a_hit = 1'b0;
      `PIC_EDGE_RISE: pin_a_hit = a_rise;
      `PIC_EDGE_FALL: pin_a_hit = a_fall;
      `PIC_EDGE_BOTH: pin_a_hit = a_rise | a_fall;
      default: pin_a_hit = 1'b0;
    endcase
    case (pin_b_edge_sel)
      `PIC_EDGE_OFF: pin_b_hit = 1'b0;
      `PIC_EDGE_RISE: pin_b_hit = b_rise;
      `PIC_EDGE_FALL: pin_b_hit = b_fall;
      `PIC_EDGE_BOTH: pin_b_hit = b_rise | b_fall;
      default: pin_b_hit = 1'b0;
    endcase
  end

  // previous pin level; reset to low so a pin high at release looks
  // like a rising edge on the first cycle after reset is released
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else begin
      pin_a_q <= ext_irq_pin_a;
      pin_b_q <= ext_irq_pin_b;
    end
  end

  // group requests share one vector: any sub-source raises the flag
  wire mg0_hit = |multi_group0_src;
  wire mg1_hit = |multi_group1_src;
  wire mg2_hit = |multi_group2_src;

  // event set vectors laid out as the flag fields
  wire [6:0] set0 = {mg0_hit, comparator_evt, pin_a_hit, 4'h0};
  wire [3:0] set1 = {timebase_zero_evt, converter_evt, mg2_hit, mg1_hit};
  wire [3:0] set2 = {async_serial_evt, serial_module_evt, pin_b_hit,
                     timebase_one_evt};

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // single-entry holding of address and data; either may come first
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_held_q | aw_fire;
  wire have_w = w_held_q | w_fire;
  wire wr_go = have_aw & have_w;
  wire [3:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire wr_lane0 = w_held_q ? wstrb_q[0] : s_axi_wstrb[0];
  wire [7:0] wb = wr_data[7:0];
  wire wr_hit = (wr_addr == `PIC_OFS_EDGE) | (wr_addr == `PIC_OFS_CTL0) |
                (wr_addr == `PIC_OFS_CTL1) | (wr_addr == `PIC_OFS_CTL2);
  wire wr_en = wr_go & wr_lane0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= `PIC_OFS_PEND;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PIC_RESP_OKAY;
    end else begin
      if (aw_fire & ~wr_go) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire & ~wr_go) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // flags are plain read/write: software clears them by writing zero,
  // and a hardware event in the same cycle still sets the flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      edge_sel_q <= `PIC_RST4;
      ctl0_q <= `PIC_RST7;
      ctl1_q <= `PIC_RST8;
      ctl2_q <= `PIC_RST8;
    end else begin
      if (wr_en && wr_addr == `PIC_OFS_EDGE) begin
        edge_sel_q <= wb[3:0];
      end
      if (wr_en && wr_addr == `PIC_OFS_CTL0) begin
        ctl0_q <= (wb[6:0] & `PIC_CTL0_WMASK) | set0;
      end else begin
        ctl0_q <= ctl0_q | set0;
      end
      if (wr_en && wr_addr == `PIC_OFS_CTL1) begin
        ctl1_q <= wb | {set1, 4'h0};
      end else begin
        ctl1_q[`PIC_FLAGS] <= ctl1_q[`PIC_FLAGS] | set1;
      end
      if (wr_en && wr_addr == `PIC_OFS_CTL2) begin
        ctl2_q <= wb | {set2, 4'h0};
      end else begin
        ctl2_q[`PIC_FLAGS] <= ctl2_q[`PIC_FLAGS] | set2;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  reg [7:0] rd_byte;
  reg rd_hit;

  // unused bits pad with zero
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `PIC_OFS_EDGE: rd_byte = {4'h0, edge_sel_q};
      `PIC_OFS_CTL0: rd_byte = {1'b0, ctl0_q};
      `PIC_OFS_CTL1: rd_byte = ctl1_q;
      `PIC_OFS_CTL2: rd_byte = ctl2_q;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PIC_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // requests to the core
  // ----------------------------------------------------------------
  // each line needs flag, own enable and global enable
  wire gie = ctl0_q[`PIC_C0_GIE];
  wire [3:0] req1 = ctl1_q[`PIC_FLAGS] & ctl1_q[`PIC_ENS];
  wire [3:0] req2 = ctl2_q[`PIC_FLAGS] & ctl2_q[`PIC_ENS];
  assign irq_pin_a = gie & ctl0_q[`PIC_C0_PINA_F] &
                     ctl0_q[`PIC_C0_PINA_E];
  assign irq_comparator = gie & ctl0_q[`PIC_C0_CMP_F] &
                          ctl0_q[`PIC_C0_CMP_E];
  assign irq_group0 = gie & ctl0_q[`PIC_C0_MG0_F] &
                      ctl0_q[`PIC_C0_MG0_E];
  assign irq_group1 = gie & req1[0];
  assign irq_group2 = gie & req1[1];
  assign irq_converter = gie & req1[2];
  assign irq_timebase0 = gie & req1[3];
  assign irq_timebase1 = gie & req2[0];
  assign irq_pin_b = gie & req2[1];
  assign irq_serial_module = gie & req2[2];
  assign irq_async_serial = gie & req2[3];
  assign irq = irq_pin_a | irq_comparator | irq_group0 | irq_group1 |
               irq_group2 | irq_converter | irq_timebase0 |
               irq_timebase1 | irq_pin_b | irq_serial_module |
               irq_async_serial;

endmodule // pic_irq_ctrl

// ---- src/pic_map.vh ----
// register offsets, field positions and reset values of the primary
// interrupt control block; assumes inclusion by the single design file
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

// byte addresses on the axi4-lite bus, one aligned word each
`define PIC_OFS_EDGE 4'h0
`define PIC_OFS_CTL0 4'h4
`define PIC_OFS_CTL1 4'h8
`define PIC_OFS_CTL2 4'hc
`define PIC_OFS_PEND 4'h0
`define PIC_AW 4

// reset value of every register
`define PIC_RST8 8'h00
`define PIC_RST7 7'h00
`define PIC_RST4 4'h0

// writable masks
`define PIC_EDGE_WMASK 8'h0f
`define PIC_CTL0_WMASK 7'h7f

// edge select encodings
`define PIC_EDGE_OFF 2'h0
`define PIC_EDGE_RISE 2'h1
`define PIC_EDGE_FALL 2'h2
`define PIC_EDGE_BOTH 2'h3

// ext_edge_select fields
`define PIC_PIN_B_SEL 3:2
`define PIC_PIN_A_SEL 1:0

// irq_ctrl_first fields
`define PIC_C0_MG0_F 6
`define PIC_C0_CMP_F 5
`define PIC_C0_PINA_F 4
`define PIC_C0_MG0_E 3
`define PIC_C0_CMP_E 2
`define PIC_C0_PINA_E 1
`define PIC_C0_GIE 0

// irq_ctrl_second / third: flags high nibble, enables low nibble
`define PIC_FLAGS 7:4
`define PIC_ENS 3:0

// axi responses
`define PIC_RESP_OKAY 2'h0
`define PIC_RESP_SLVERR 2'h2

`endif

// ---- verification/pic_irq_ctrl_asserts.sv ----
// port-level properties of the interrupt controller
// assumes a bind onto pic_irq_ctrl; one clock, sync low reset
`timescale 1ns/1ns
module pic_irq_ctrl_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire ext_irq_pin_a,
  input wire comparator_evt,
  input wire [7:0] multi_group0_src,
  input wire irq_pin_a,
  input wire irq_comparator,
  input wire irq_group0,
  input wire irq
);
  reg [3:0] rd_addr_q;
  wire wr_take = s_axi_awvalid && s_axi_awready ||
    s_axi_wvalid && s_axi_wready;
  // remember the read address so data can be judged per register
  always @(posedge aclk) begin
    if (!aresetn)
      rd_addr_q <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr_q <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  read_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("no read answer");
  write_answer_a: assert property (aw_w_take |=> s_axi_bvalid)
    else $error("no write answer");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  edge_upper_a: assert property (s_axi_rvalid && rd_addr_q == 4'h0 |->
    s_axi_rdata[31:4] == 28'h0) else $error("edge upper bits");
  ctl0_top_a: assert property (s_axi_rvalid && rd_addr_q == 4'h4 |->
    s_axi_rdata[31:7] == 25'h0) else $error("ctl0 top bit");
  irq_gate_a: assert property (!irq |-> !irq_comparator &&
    !irq_pin_a && !irq_group0) else $error("irq not merged");
  sticky_cmp_a: assert property ($fell(irq_comparator) |->
    $past(wr_take)) else $error("cmp flag lost");
  cmp_cause_a: assert property ($rose(irq_comparator) |->
    $past(wr_take || comparator_evt)) else $error("cmp rise");
  grp0_cause_a: assert property ($rose(irq_group0) |->
    $past(wr_take || |multi_group0_src)) else $error("grp0");
  pina_cause_a: assert property ($rose(irq_pin_a) |-> $past(wr_take) ||
    $past(ext_irq_pin_a) != $past(ext_irq_pin_a, 2))
    else $error("pin a rise");
endmodule // pic_irq_ctrl_asserts

bind pic_irq_ctrl pic_irq_ctrl_asserts u_chk (.*);

// ---- verification/pic_irq_ctrl_tb_top.sv ----
// register-level testbench of the interrupt controller
// assumes pic_map.vh on the include path and the source model
`timescale 1ns/1ns
`include "pic_map.vh"
module primary_irq_ctrl_edge_select_tb_top;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg s_axi_arvalid, s_axi_rready, ext_irq_pin_a, ext_irq_pin_b, ok;
  reg [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  reg [31:0] s_axi_wdata;
  reg [8:0] kick;
  integer num_errors, cmp_count, i;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, irq, irq_pin_a, irq_comparator, irq_group0;
  wire irq_group1, irq_group2, irq_converter, irq_timebase0;
  wire irq_timebase1, irq_serial_module, irq_async_serial, irq_pin_b;
  wire comparator_evt, converter_evt, timebase_zero_evt;
  wire timebase_one_evt, serial_module_evt, async_serial_evt;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] multi_group0_src, multi_group1_src, multi_group2_src;
  wire [11:0] lines = {irq, irq_pin_a, irq_comparator, irq_group0,
    irq_group1, irq_group2, irq_converter, irq_timebase0, irq_timebase1,
    irq_serial_module, irq_async_serial, irq_pin_b};
  pic_irq_ctrl uut (.*);
  pic_src_model u_src (.*);
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // one bus transfer; holds each channel until its handshake edge
  task xfer(input w, input [3:0] a, input [7:0] d, input [7:0] ex,
      input [1:0] er);
    integer n;
    begin
      ok = 0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (n = 0; n < 64 && !ok; n = n + 1) begin
        @(posedge aclk);
        // each channel is released at its own handshake edge
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
        ok = w ? s_axi_bvalid && s_axi_bready :
          s_axi_rvalid && s_axi_rready;
        if (ok)
          check({30'h0, w ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
        if (ok && !w && er === `PIC_RESP_OKAY)
          check(s_axi_rdata, {24'h0, ex});
        if (ok) begin
          s_axi_bready <= 1'b0;
          s_axi_rready <= 1'b0;
        end
      end
      @(posedge aclk);
      if (!ok) begin
        num_errors = num_errors + 1;
        end_sim;
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    xfer(1'b1, a, d, 8'h00, `PIC_RESP_OKAY);
  endtask
  task rd(input [3:0] a, input [7:0] ex);
    xfer(1'b0, a, 8'h00, ex, `PIC_RESP_OKAY);
  endtask
  // kick sources, then give the flags time to land
  task fire(input [8:0] k);
    begin
      kick <= k;
      @(posedge aclk);
      kick <= 9'h000;
      repeat (3) @(posedge aclk);
    end
  endtask
  // own loop index so callers looping on i are not disturbed
  task clear_all;
    integer j;
    begin
      for (j = 0; j < 4; j = j + 1)
        wr({j[1:0], 2'b00}, 8'h00);
    end
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, ext_irq_pin_a, ext_irq_pin_b} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    kick = 9'h000;
    num_errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
      rd({i[1:0], 2'b00}, 8'h00);
    xfer(1'b0, 4'h2, 8'h00, 8'h00, `PIC_RESP_SLVERR);
    xfer(1'b1, 4'h2, 8'hff, 8'h00, `PIC_RESP_SLVERR);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1)
      wr({i[1:0], 2'b00}, 8'hff);
    rd(`PIC_OFS_EDGE, 8'h0f);
    rd(`PIC_OFS_CTL0, 8'h7f);
    rd(`PIC_OFS_CTL1, 8'hff);
    rd(`PIC_OFS_CTL2, 8'hff);
    check(lines, 12'hfff);
    wr(`PIC_OFS_CTL0, 8'h7e);
    check(lines[11:8], 4'h0);
    clear_all;
    $display("test masks done");
    wr(`PIC_OFS_CTL0, 8'h05);
    fire(9'h001);
    rd(`PIC_OFS_CTL0, 8'h25);
    check(lines, 12'ha00);
    wr(`PIC_OFS_CTL0, 8'h21);
    check(lines, 12'h000);
    rd(`PIC_OFS_CTL0, 8'h21);
    fire(9'h1fe);
    rd(`PIC_OFS_CTL0, 8'h61);
    rd(`PIC_OFS_CTL1, 8'hf0);
    rd(`PIC_OFS_CTL2, 8'hd0);
    check(lines, 12'h000);
    wr(`PIC_OFS_CTL0, 8'h49);
    check(lines, 12'h900);
    clear_all;
    $display("test sources done");
    // every edge mode on both pins: rise then fall
    for (i = 0; i < 4; i = i + 1) begin
      wr(`PIC_OFS_EDGE, {4'h0, i[1:0], i[1:0]});
      {ext_irq_pin_a, ext_irq_pin_b} <= 2'b11;
      repeat (2) @(posedge aclk);
      rd(`PIC_OFS_CTL0, {3'h0, i[0], 4'h0});
      rd(`PIC_OFS_CTL2, {2'h0, i[0], 5'h0});
      clear_all;
      wr(`PIC_OFS_EDGE, {4'h0, i[1:0], i[1:0]});
      {ext_irq_pin_a, ext_irq_pin_b} <= 2'b00;
      repeat (2) @(posedge aclk);
      rd(`PIC_OFS_CTL0, {3'h0, i[1], 4'h0});
      rd(`PIC_OFS_CTL2, {2'h0, i[1], 5'h0});
      clear_all;
    end
    $display("test edges done");
    end_sim;
  end
endmodule // primary_irq_ctrl_edge_select_tb_top

// ---- verification/pic_src_model.sv ----
// peripheral event source model for the interrupt controller
// assumes kicks are driven just after a rising edge of aclk
`timescale 1ns/1ns
module pic_src_model (
  input wire aclk,
  input wire [8:0] kick,
  output reg comparator_evt,
  output reg [7:0] multi_group0_src,
  output reg [7:0] multi_group1_src,
  output reg [7:0] multi_group2_src,
  output reg converter_evt,
  output reg timebase_zero_evt,
  output reg timebase_one_evt,
  output reg serial_module_evt,
  output reg async_serial_evt
);
  // one-cycle pulse per kick; groups use differing sub-source lines
  always @(posedge aclk) begin
    comparator_evt <= kick[0];
    multi_group0_src <= {4'h0, kick[1], 3'h0};
    multi_group1_src <= {kick[2], 7'h00};
    multi_group2_src <= {7'h00, kick[3]};
    converter_evt <= kick[4];
    timebase_zero_evt <= kick[5];
    timebase_one_evt <= kick[6];
    serial_module_evt <= kick[7];
    async_serial_evt <= kick[8];
  end
endmodule // pic_src_model
